// ==== include/rtc_cal_pkg.sv ====
package rtc_cal_pkg;
  // Register map, byte addresses on the internal bus
  localparam logic [15:0] DAY_ADDR = 16'h1324;
  localparam logic [15:0] MONTH_ADDR = 16'h1325;
  localparam logic [15:0] YEAR_ADDR = 16'h1326;
  localparam logic [15:0] PAGE_ADDR = 16'h1327;
  localparam logic [15:0] RESET_ADDR = 16'h1328;
  // Field positions in the page register
  localparam int PG_BANK_BIT = 0;
  localparam int PG_ALARM_BIT = 2;
  localparam int PG_RUN_BIT = 3;
  localparam int PG_ADJUST_BIT = 4;
  localparam int PG_IRQ_BIT = 7;
  // Field positions in the reset register
  localparam int RS_MATCH_CLR_BIT = 4;
  localparam int RS_DIV_CLR_BIT = 5;
  localparam int RS_16HZ_OFF_BIT = 6;
  localparam int RS_1HZ_OFF_BIT = 7;
  // Field widths
  localparam int DAY_W = 6;
  localparam int MONTH_W = 5;
  localparam int YEAR_W = 8;
  localparam int LEAP_W = 2;
  // Reset value of the only reset field
  localparam logic IRQ_EN_RST = 1'b0;
  // Seconds boundary for the adjust decision, BCD
  localparam logic [6:0] ADJ_HALF_SEC = 7'h30;
  // Divider chain: 15 stages from the 32768 Hz oscillator
  localparam int OSC_HZ = 32768;
  localparam int DIV_W = $clog2(OSC_HZ);
  localparam int DIV_1HZ_BIT = DIV_W - 1;
  localparam int DIV_16HZ_BIT = $clog2(OSC_HZ / 32);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(OSC_HZ - 1);
  // Register port request
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;
endpackage

// ==== rtl/rtc_calendar_control_regs.sv ====
// Design decision made here: strobed register access.
`timescale 1ns/1ps
// Contract
// RL1 - Day register holds six-bit BCD day on both pages, upper bits read zero.
// RL2 - Software never loads a day that does not exist in the month.
// RL3 - Time page month register holds five-bit BCD month 01 to 12.
// RL4 - Alarm page month address holds one hour-format bit, one means 24-hour.
// RL5 - Time page year register holds eight-bit BCD year 00 to 99.
// RL6 - Alarm page year address holds two-bit leap phase in bits 1:0.
// RL7 - Page register: bank select bit0, irq enable bit7, run bit3, alarm bit2.
// RL8 - Software writes clock and alarm enables before the interrupt enable.
// RL9 - Adjust with seconds 0 to 29 clears seconds, minutes untouched.
// RL10 - Adjust with seconds 30 to 59 carries into minutes and clears seconds.
// RL11 - Adjust is a one-cycle internal pulse, time page only.
// RL12 - Adjust bit is write-only and self-clearing; writing zero does nothing.
// RL13 - Write-only reset register: 1 Hz off, 16 Hz off, divider clear, match clear.
// RL14 - Writing one to match clear reinitialises alarm comparison; zero does nothing.
// RL15 - Count-up stays in step with the 1 Hz falling edge.
// RL16 - Interrupt is one pulse per falling edge of the alarm source.
// RL17 - Alarm off, 1 Hz on, 16 Hz off drives 1 Hz onto the alarm pin.
// RL18 - Alarm off, 1 Hz off, 16 Hz on drives 16 Hz onto the alarm pin.
// RL19 - Shared addresses route to time or alarm bank by the bank bit.
// RL20 - Reset clears only the interrupt enable; calendar and controls keep values.
module rtc_calendar_control_regs (
  // Clock and reset
  input wire logic MCLK,
  input wire logic RESET_N,
  // Register port
  input wire rtc_cal_pkg::bus_req_t BUS,
  output logic [7:0] RDATA,
  // Seconds counter outside this block, same clock
  input wire logic [6:0] SECONDS,
  output logic SEC_TICK,
  output logic ADJ_CLEAR,
  output logic ADJ_CARRY,
  // Alarm comparison outside this block, same clock
  input wire logic ALARM_MATCH,
  output logic MATCH_CLEAR,
  output logic HOUR_24,
  // Oscillator pin and alarm pin
  input wire logic OSC32K,
  output logic ALARM_N,
  output logic RTC_IRQ
);
  import rtc_cal_pkg::*;

  // Calendar and control storage; only the interrupt enable has a reset, so the rest survives system reset
  logic [DAY_W-1:0] day_reg, day_next;
  logic [MONTH_W-1:0] month_reg, month_next;
  logic [YEAR_W-1:0] year_reg, year_next;
  logic [LEAP_W-1:0] leap_reg, leap_next;
  logic hour24_reg, hour24_next;
  logic bank_reg, bank_next;
  logic run_reg, run_next;
  logic alarm_en_reg, alarm_en_next;
  logic off1_reg, off1_next;
  logic off16_reg, off16_next;
  logic irq_en_reg, irq_en_next;
  logic [7:0] rdata_reg, rdata_next;

  logic wr_day, wr_month, wr_year, wr_page, wr_reset;

  assign wr_day = BUS.wr && (BUS.addr == DAY_ADDR);
  assign wr_month = BUS.wr && (BUS.addr == MONTH_ADDR);
  assign wr_year = BUS.wr && (BUS.addr == YEAR_ADDR);
  assign wr_page = BUS.wr && (BUS.addr == PAGE_ADDR);
  assign wr_reset = BUS.wr && (BUS.addr == RESET_ADDR);

  // Register writes; bank bit picks which copy a shared address reaches
  always_comb begin
    day_next = day_reg;
    month_next = month_reg;
    year_next = year_reg;
    leap_next = leap_reg;
    hour24_next = hour24_reg;
    bank_next = bank_reg;
    run_next = run_reg;
    alarm_en_next = alarm_en_reg;
    off1_next = off1_reg;
    off16_next = off16_reg;
    irq_en_next = irq_en_reg;
    if (wr_day) begin
      day_next = BUS.wdata[DAY_W-1:0]; // see RL1
    end
    if (wr_month) begin
      if (bank_reg) begin // see RL19
        hour24_next = BUS.wdata[0]; // see RL4
      end else begin
        month_next = BUS.wdata[MONTH_W-1:0]; // see RL3
      end
    end
    if (wr_year) begin
      if (bank_reg) begin // see RL19
        leap_next = BUS.wdata[LEAP_W-1:0]; // see RL6
      end else begin
        year_next = BUS.wdata; // see RL5
      end
    end
    if (wr_page) begin
      bank_next = BUS.wdata[PG_BANK_BIT]; // see RL7
      run_next = BUS.wdata[PG_RUN_BIT];
      alarm_en_next = BUS.wdata[PG_ALARM_BIT];
      irq_en_next = BUS.wdata[PG_IRQ_BIT];
    end
    if (wr_reset) begin
      off1_next = BUS.wdata[RS_1HZ_OFF_BIT]; // see RL13
      off16_next = BUS.wdata[RS_16HZ_OFF_BIT];
    end
  end

  always_ff @(posedge MCLK) begin
    day_reg <= day_next;
    month_reg <= month_next;
    year_reg <= year_next;
    leap_reg <= leap_next;
    hour24_reg <= hour24_next;
    bank_reg <= bank_next;
    run_reg <= run_next;
    alarm_en_reg <= alarm_en_next;
    off1_reg <= off1_next;
    off16_reg <= off16_next;
  end

  // Only the interrupt enable is cleared by system reset
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      irq_en_reg <= IRQ_EN_RST; // see RL20
    end else begin
      irq_en_reg <= irq_en_next;
    end
  end

  // Read data one cycle after the strobe; adjust and reset register read zero
  always_comb begin
    rdata_next = 8'h00;
    if (BUS.rd) begin
      unique case (BUS.addr)
        DAY_ADDR: rdata_next = {2'h0, day_reg}; // see RL1
        MONTH_ADDR: rdata_next = bank_reg ? {7'h00, hour24_reg} : {3'h0, month_reg}; // see RL19
        YEAR_ADDR: rdata_next = bank_reg ? {6'h00, leap_reg} : year_reg;
        PAGE_ADDR: begin
          rdata_next[PG_IRQ_BIT] = irq_en_reg; // see RL7
          rdata_next[PG_RUN_BIT] = run_reg;
          rdata_next[PG_ALARM_BIT] = alarm_en_reg;
          rdata_next[PG_BANK_BIT] = bank_reg;
        end
        default: rdata_next = 8'h00;
      endcase
    end
  end

  // Oscillator pin crossing: sync1 feeds only sync2
  logic osc_sync1_reg, osc_sync2_reg, osc_last_reg;
  logic osc_rise;

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      osc_sync1_reg <= 1'b0;
      osc_sync2_reg <= 1'b0;
      osc_last_reg <= 1'b0;
    end else begin
      osc_sync1_reg <= OSC32K;
      osc_sync2_reg <= osc_sync1_reg;
      osc_last_reg <= osc_sync2_reg;
    end
  end

  assign osc_rise = osc_sync2_reg && !osc_last_reg;

  // Divider chain and carry hold; the divider is not cleared by system reset but stops counting while reset is held
  logic [DIV_W-1:0] div_reg, div_next;
  logic hold_reg, hold_next;
  logic wrap;
  logic tick_reg, tick_next;

  assign wrap = osc_rise && (div_reg == DIV_LAST);

  always_comb begin
    div_next = div_reg;
    hold_next = hold_reg;
    tick_next = 1'b0;
    if (osc_rise) begin
      div_next = div_reg + 1'b1;
    end
    // A carry while stopped is held, then released once running again
    if (wrap || hold_reg) begin
      if (run_reg) begin
        tick_next = 1'b1; // see RL15
        hold_next = 1'b0;
      end else begin
        hold_next = 1'b1;
      end
    end
    if (wr_reset && BUS.wdata[RS_DIV_CLR_BIT]) begin
      div_next = '0; // see RL13
      hold_next = 1'b0;
    end
  end

  always_ff @(posedge MCLK) begin
    div_reg <= div_next;
    hold_reg <= hold_next;
  end

  // Adjust and clear pulses; written ones act once, zeros are ignored
  logic adj_clear_reg, adj_clear_next;
  logic adj_carry_reg, adj_carry_next;
  logic match_clr_reg, match_clr_next;
  logic adj_req;

  // Adjust only takes effect with the time bank selected by this write
  assign adj_req = wr_page && BUS.wdata[PG_ADJUST_BIT] && !BUS.wdata[PG_BANK_BIT]; // see RL11

  always_comb begin
    adj_clear_next = 1'b0; // see RL12
    adj_carry_next = 1'b0;
    if (adj_req) begin
      adj_clear_next = 1'b1; // see RL9
      adj_carry_next = (SECONDS >= ADJ_HALF_SEC); // see RL10
    end
    match_clr_next = wr_reset && BUS.wdata[RS_MATCH_CLR_BIT]; // see RL14
  end

  // Alarm pin source mux; unlisted combinations hold the pin low
  logic src_reg, src_next;
  logic irq_reg, irq_next;

  always_comb begin
    src_next = 1'b0;
    if (alarm_en_reg && off1_reg && off16_reg) begin
      src_next = !ALARM_MATCH;
    end else if (!alarm_en_reg && !off1_reg && off16_reg) begin
      src_next = div_reg[DIV_1HZ_BIT]; // see RL17
    end else if (!alarm_en_reg && off1_reg && !off16_reg) begin
      src_next = div_reg[DIV_16HZ_BIT]; // see RL18
    end
    irq_next = irq_en_reg && src_reg && !src_next; // see RL16
  end

  // Pulses and pin levels come from flops with defined reset values
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rdata_reg <= 8'h00;
      tick_reg <= 1'b0;
      adj_clear_reg <= 1'b0;
      adj_carry_reg <= 1'b0;
      match_clr_reg <= 1'b0;
      src_reg <= 1'b1;
      irq_reg <= 1'b0;
    end else begin
      rdata_reg <= rdata_next;
      tick_reg <= tick_next;
      adj_clear_reg <= adj_clear_next;
      adj_carry_reg <= adj_carry_next;
      match_clr_reg <= match_clr_next;
      src_reg <= src_next;
      irq_reg <= irq_next;
    end
  end

  assign RDATA = rdata_reg;
  assign SEC_TICK = tick_reg;
  assign ADJ_CLEAR = adj_clear_reg;
  assign ADJ_CARRY = adj_carry_reg;
  assign MATCH_CLEAR = match_clr_reg;
  assign HOUR_24 = hour24_reg;
  assign ALARM_N = src_reg;
  assign RTC_IRQ = irq_reg;

  // Checks
  property p_day_read;
    @(posedge MCLK) disable iff (!RESET_N)
      BUS.rd && BUS.addr == DAY_ADDR |=> RDATA[7:6] == 2'h0;
  endproperty
  a_day_read: assert property (p_day_read) else $error("day upper bits not zero"); // see RL1

  property p_month_bank;
    @(posedge MCLK) disable iff (!RESET_N)
      BUS.rd && BUS.addr == MONTH_ADDR && bank_reg |=> RDATA[7:1] == 7'h00;
  endproperty
  a_month_bank: assert property (p_month_bank) else $error("format read nonzero"); // see RL4

  property p_year_write;
    @(posedge MCLK)
      wr_year && !bank_reg |=> year_reg == $past(BUS.wdata);
  endproperty
  a_year_write: assert property (p_year_write) else $error("year not stored"); // see RL5

  property p_adj_low;
    @(posedge MCLK) disable iff (!RESET_N)
      adj_req && SECONDS < ADJ_HALF_SEC |=> ADJ_CLEAR && !ADJ_CARRY;
  endproperty
  a_adj_low: assert property (p_adj_low) else $error("low adjust wrong"); // see RL9

  property p_adj_high;
    @(posedge MCLK) disable iff (!RESET_N)
      adj_req && SECONDS >= ADJ_HALF_SEC |=> ADJ_CLEAR && ADJ_CARRY;
  endproperty
  a_adj_high: assert property (p_adj_high) else $error("high adjust wrong"); // see RL10

  property p_adj_one;
    @(posedge MCLK) disable iff (!RESET_N)
      ADJ_CLEAR && !$past(adj_req) |-> 1'b0;
  endproperty
  a_adj_one: assert property (p_adj_one) else $error("adjust without request"); // see RL11

  property p_adj_self;
    @(posedge MCLK) disable iff (!RESET_N)
      ADJ_CLEAR && !adj_req |=> !ADJ_CLEAR;
  endproperty
  a_adj_self: assert property (p_adj_self) else $error("adjust stuck"); // see RL12

  property p_match_clr;
    @(posedge MCLK) disable iff (!RESET_N)
      wr_reset |=> MATCH_CLEAR == $past(BUS.wdata[RS_MATCH_CLR_BIT]);
  endproperty
  a_match_clr: assert property (p_match_clr) else $error("match clear wrong"); // see RL14

  property p_irq_edge;
    @(posedge MCLK) disable iff (!RESET_N)
      RTC_IRQ |-> $fell(ALARM_N) && $past(irq_en_reg);
  endproperty
  a_irq_edge: assert property (p_irq_edge) else $error("irq without falling edge"); // see RL16

  property p_irq_en_rst;
    @(posedge MCLK) $rose(RESET_N) |-> !irq_en_reg;
  endproperty
  a_irq_en_rst: assert property (p_irq_en_rst) else $error("irq enable not reset"); // see RL20

  c_adjust_carry: cover property (@(posedge MCLK) ADJ_CARRY);
  c_irq: cover property (@(posedge MCLK) RTC_IRQ);
  // The count-up leads the registered pin by one cycle, so both land at the same edge downstream
  c_tick: cover property (@(posedge MCLK) SEC_TICK ##1 $fell(ALARM_N));
endmodule

// ==== verification/rtc_calendar_control_regs_tb.sv ====
`timescale 1ns/1ps
module rtc_calendar_control_regs_tb;
  import rtc_cal_pkg::*;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  bus_req_t bus = '0;
  logic [6:0] seconds = 7'h00;
  logic alarm_match = 1'b0;
  logic osc32k = 1'b0;
  logic [7:0] rdata;
  logic sec_tick, adj_clear, adj_carry, match_clear, hour_24, alarm_n, rtc_irq;
  int errors = 0;
  int check_count = 0;

  // 40 MHz system clock
  always #12.5 mclk = ~mclk;
  // Oscillator at half the system rate, so one second lasts 65536 cycles
  always @(posedge mclk) osc32k <= ~osc32k;

  rtc_calendar_control_regs rtc_calendar_control_regs_inst (
    .MCLK(mclk),
    .RESET_N(reset_n),
    .BUS(bus),
    .RDATA(rdata),
    .SECONDS(seconds),
    .SEC_TICK(sec_tick),
    .ADJ_CLEAR(adj_clear),
    .ADJ_CARRY(adj_carry),
    .ALARM_MATCH(alarm_match),
    .MATCH_CLEAR(match_clear),
    .HOUR_24(hour_24),
    .OSC32K(osc32k),
    .ALARM_N(alarm_n),
    .RTC_IRQ(rtc_irq)
  );

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Write cycle; returns at the edge that takes it
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge mclk);
    bus.addr <= a;
    bus.wdata <= d;
    bus.wr <= 1'b1;
    @(posedge mclk);
    bus.wr <= 1'b0;
  endtask

  // Read cycle; data is looked at only in the cycle after the strobe
  task automatic rchk(input logic [15:0] a, input logic [7:0] exp);
    @(posedge mclk);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge mclk);
    bus.rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask

  // Cycles until the alarm pin falls, bounded so a dead pin cannot hang
  // Also returns the tick level seen in the cycle just before the fall
  task automatic next_fall(output int n, output logic tick_prev);
    logic prev;
    n = 0;
    tick_prev = 1'b0;
    // Step off the edge so the pin is never read while it is being launched
    #1;
    do begin
      prev = alarm_n;
      tick_prev = sec_tick;
      @(posedge mclk);
      #1;
      n++;
    end while (!(prev === 1'b1 && alarm_n === 1'b0) && n < 70000);
  endtask

  task automatic t_calendar();
    wr(PAGE_ADDR, 8'h08);
    wr(DAY_ADDR, 8'hff);
    wr(MONTH_ADDR, 8'hff);
    wr(YEAR_ADDR, 8'h99);
    rchk(DAY_ADDR, 8'h3f);
    rchk(MONTH_ADDR, 8'h1f);
    wr(MONTH_ADDR, 8'h12);
    rchk(MONTH_ADDR, 8'h12);
    rchk(YEAR_ADDR, 8'h99);
    // Alarm bank: same addresses, different storage for month and year, same for day
    wr(PAGE_ADDR, 8'h09);
    wr(MONTH_ADDR, 8'hff);
    #1 chk(hour_24, 1'b1);
    rchk(MONTH_ADDR, 8'h01);
    wr(MONTH_ADDR, 8'hfe);
    #1 chk(hour_24, 1'b0);
    for (int k = 0; k < 4; k++) begin
      wr(YEAR_ADDR, 8'hfc | 8'(k));
      rchk(YEAR_ADDR, 8'(k));
    end
    rchk(DAY_ADDR, 8'h3f);
    wr(DAY_ADDR, 8'h28); // Valid day in any month
    wr(PAGE_ADDR, 8'h08);
    rchk(MONTH_ADDR, 8'h12);
    rchk(YEAR_ADDR, 8'h99);
    rchk(DAY_ADDR, 8'h28);
    rchk(16'h1329, 8'h00);
    rchk(RESET_ADDR, 8'h00);
  endtask

  task automatic t_page();
    wr(PAGE_ADDR, 8'h0c); // Enables before interrupt
    rchk(PAGE_ADDR, 8'h0c);
    wr(PAGE_ADDR, 8'h8c);
    rchk(PAGE_ADDR, 8'h8c);
    wr(PAGE_ADDR, 8'hee);
    rchk(PAGE_ADDR, 8'h8c);
    // Reset in mid-run must only drop the interrupt enable
    @(posedge mclk);
    reset_n <= 1'b0;
    repeat (2) @(posedge mclk);
    reset_n <= 1'b1;
    rchk(PAGE_ADDR, 8'h0c);
    rchk(YEAR_ADDR, 8'h99);
  endtask

  task automatic t_adjust();
    logic [6:0] secs [4] = '{7'h00, 7'h29, 7'h30, 7'h59};
    logic [7:0] bad [2] = '{8'h1d, 8'h0c};
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk);
      seconds <= secs[i];
      wr(PAGE_ADDR, 8'h1c);
      #1 chk(adj_clear, 1'b1);
      chk(adj_carry, i > 1);
      @(posedge mclk);
      #1 chk({adj_clear, adj_carry}, 2'b00);
      rchk(PAGE_ADDR, 8'h0c);
    end
    // Alarm bank or adjust zero: no pulse
    for (int i = 0; i < 2; i++) begin
      wr(PAGE_ADDR, bad[i]);
      #1 chk(adj_clear, 1'b0);
    end
  endtask

  task automatic t_alarm();
    wr(RESET_ADDR, 8'hd0);
    #1 chk(match_clear, 1'b1);
    @(posedge mclk);
    #1 chk(match_clear, 1'b0);
    wr(RESET_ADDR, 8'hc0);
    #1 chk(match_clear, 1'b0);
    wr(PAGE_ADDR, 8'h8c);
    #1 chk(alarm_n, 1'b1);
    for (int i = 0; i < 2; i++) begin
      @(posedge mclk);
      alarm_match <= 1'b1;
      @(posedge mclk);
      #1 chk(alarm_n, 1'b0);
      chk(rtc_irq, i == 0);
      @(posedge mclk);
      alarm_match <= 1'b0;
      #1 chk(rtc_irq, 1'b0);
      wr(PAGE_ADDR, 8'h0c);
    end
  endtask

  task automatic t_square();
    int n;
    logic tk;
    wr(PAGE_ADDR, 8'h88);
    wr(RESET_ADDR, 8'ha0);
    next_fall(n, tk);
    next_fall(n, tk);
    chk(n, 4096);
    chk(rtc_irq, 1'b1);
    // Divider clear with the 1 Hz source; skip the drop that the clear itself causes
    wr(RESET_ADDR, 8'h60);
    repeat (3) @(posedge mclk);
    next_fall(n, tk);
    chk(n > 65520 && n < 65545, 1'b1);
    chk(tk, 1'b1);
    chk(sec_tick, 1'b0);
    chk(rtc_irq, 1'b1);
  endtask

  initial begin
    repeat (10) @(posedge mclk);
    reset_n <= 1'b1;
    t_calendar();
    t_page();
    t_adjust();
    t_alarm();
    t_square();
    conclude();
  end

  // Watchdog: the run needs about 75000 cycles, limit at 90000
  initial begin
    #2250000;
    errors++;
    conclude();
  end
endmodule
